// file: src/loop_det_pkg.sv
// Purpose: Constants shared by the scanning loop period detector
// Assumes: 250 MHz system clock, 32 MHz count reference as an enable input
// Notes: Sensitivity codes 0 = off, 1..9 levels, 15 = forced call
package loop_det_pkg;
    localparam int CLK_MHZ = 250;
    localparam int NUM_CH = 4;
    localparam int CNT_W = 24;
    localparam int RESTORE_S = 5;
    localparam int RESTORE_CYC = RESTORE_S * CLK_MHZ * 1000000;
    localparam int FLASH3_CYC = (CLK_MHZ * 1000000) / 6;
    localparam logic [3:0] SENS_OFF = 4'h0;
    localparam logic [3:0] SENS_CALL = 4'hf;
    localparam logic [3:0] SENS_DEF = 4'h4;
    localparam logic [2:0] FREQ_DEF = 3'h0;
    localparam logic [CNT_W-1:0] CNT_MIN = 24'h000400;
    localparam logic [CNT_W-1:0] CNT_MAX = 24'h800000;
    localparam int FAIL_SHIFT = 2;
    localparam int DRIFT_SHIFT = 6;
    localparam logic [7:0] MIN_CYCLES = 8'h08;
    typedef enum logic [1:0] {ST_ENABLE, ST_SAMPLE, ST_EVAL} scan_e;
endpackage

// file: src/loop_period_detector.sv
// Purpose: Four channel scanning loop period detector
// Assumes: sq_in synchronous; tick_32m pulses at 32 MHz
// Notes: Output timers arrive as a combined hold count input
`timescale 1ns/1ps
module loop_period_detector (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tick_32m,
    input wire logic sq_in,
    input wire logic [3:0] switch_in,
    input wire logic set_we,
    input wire logic [1:0] set_ch,
    input wire logic [3:0] set_sens,
    input wire logic [2:0] set_freq,
    input wire logic [15:0] hold_ticks,
    input wire logic [1:0] disp_ch,
    output logic [3:0] osc_en,
    output logic [11:0] cap_sel,
    output logic [3:0] call_out,
    output logic [3:0] led_out,
    output logic [3:0] fail_out,
    output logic [3:0] fail_mem,
    output logic [loop_det_pkg::CNT_W-1:0] disp_count,
    output logic [7:0] disp_pct,
    output logic disp_all_on,
    output logic [2:0] restore_countdown,
    output logic restore_pulse
);
    localparam int CNT_W_P = loop_det_pkg::CNT_W;

    logic [3:0] sens_r [4];
    logic [2:0] freq_r [4];
    logic [CNT_W_P-1:0] ref_r [4];
    logic [CNT_W_P-1:0] last_r [4];
    logic [3:0] det_r;
    logic [3:0] fail_r;
    logic [3:0] mem_r;
    logic [3:0] chreset_r;
    logic [15:0] hold_r [4];
    loop_det_pkg::scan_e st_r;
    logic [1:0] ch_r;
    logic [7:0] ncyc_r;
    logic [CNT_W_P-1:0] acc_r;
    logic sq_d_r;
    logic [31:0] rest_cnt_r;
    logic [31:0] flash_cnt_r;
    logic flash_r;
    logic [3:0] osc_en_r;
    logic [3:0] call_r;
    logic [3:0] led_r;
    logic [CNT_W_P-1:0] dcount_r;
    logic [7:0] dpct_r;
    logic all_on_r;
    logic [2:0] cd_r;
    logic rest_p_r;
    logic [31:0] sec_cnt_r;
    logic [2:0] secs_left_r;
    logic [CNT_W_P-1:0] stall_r;

    // Oscillations per sample from the low three sensitivity bits, doubling per level up to 4
    function automatic logic [7:0] cycles_for(input logic [3:0] s);
        cycles_for = loop_det_pkg::MIN_CYCLES << s[2:0];
    endfunction

    // Threshold as a shift of reference: higher sensitivity, smaller share
    function automatic logic [CNT_W_P-1:0] thresh_for(input logic [CNT_W_P-1:0] r,
                                                  input logic [3:0] s);
        thresh_for = r >> (5'd4 + {1'b0, s});
    endfunction

    wire [2:0] pressed = 3'(switch_in[0]) + 3'(switch_in[1]) + 3'(switch_in[2])
                       + 3'(switch_in[3]);
    wire all_held = (pressed == 3'd4);
    wire test_on = (pressed == 3'd2) || (pressed == 3'd3);
    wire restore_done = all_held && (rest_cnt_r == 32'(loop_det_pkg::RESTORE_CYC - 1));
    wire sq_rise = sq_in && !sq_d_r;
    wire [3:0] cur_sens = sens_r[ch_r];
    wire [CNT_W_P-1:0] cur_ref = ref_r[ch_r];
    wire cur_active = (cur_sens != loop_det_pkg::SENS_OFF)
                    && (cur_sens != loop_det_pkg::SENS_CALL);
    wire below = acc_r < cur_ref;
    wire [CNT_W_P-1:0] delta = below ? cur_ref - acc_r : acc_r - cur_ref;
    wire over_thr = below && (delta > thresh_for(cur_ref, cur_sens));
    wire range_bad = (acc_r < loop_det_pkg::CNT_MIN)
                   || (acc_r > loop_det_pkg::CNT_MAX);
    wire abrupt = (ref_r[ch_r] != '0)
                && (delta > (cur_ref >> loop_det_pkg::FAIL_SHIFT));
    wire [CNT_W_P-1:0] drift_step = (delta >> loop_det_pkg::DRIFT_SHIFT) | 24'h000001;
    // Widened so the scaled change keeps its top bits before the divide
    wire [31:0] pct_num = {8'h00, delta} << 7;
    wire [31:0] pct_den = {8'h00, cur_ref | 24'h000001};
    wire [31:0] pct_w = pct_num / pct_den;
    wire [7:0] pct_sat = (pct_w > 32'h000000ff) ? 8'hff : pct_w[7:0];

    // Outcome of the sample under evaluation
    wire eval_now = (st_r == loop_det_pkg::ST_EVAL);
    wire eval_fail = range_bad || abrupt;
    wire eval_det = cur_active && over_thr && !range_bad;
    // Equal counts leave the reference alone, so it does not creep by one
    wire eval_track = !over_thr && !eval_fail && (delta != '0);
    wire [CNT_W_P-1:0] ref_tracked = below ? cur_ref - drift_step : cur_ref + drift_step;
    wire sec_wrap = (sec_cnt_r == 32'(loop_det_pkg::RESTORE_CYC / loop_det_pkg::RESTORE_S - 1));
    // A loop that never oscillates would otherwise stall the whole scan
    wire stall_out = (stall_r == loop_det_pkg::CNT_MAX);

    // Front-panel gestures; scan state is untouched here
    always_ff @(posedge clock) begin
        if (!rst_n || !all_held) begin
            rest_cnt_r <= '0;
        end else if (!restore_done) begin
            rest_cnt_r <= rest_cnt_r + 32'd1;
        end else begin
            rest_cnt_r <= '0;
        end
    end

    // Whole seconds left; a ticker avoids a wide divider on the counter
    always_ff @(posedge clock) begin
        if (!rst_n || !all_held) begin
            sec_cnt_r <= '0;
            secs_left_r <= 3'(loop_det_pkg::RESTORE_S);
        end else if (sec_wrap) begin
            sec_cnt_r <= '0;
            if (secs_left_r != 3'd1) begin
                secs_left_r <= secs_left_r - 3'd1;
            end
        end else begin
            sec_cnt_r <= sec_cnt_r + 32'd1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cd_r <= '0;
            rest_p_r <= 1'b0;
            all_on_r <= 1'b0;
        end else begin
            cd_r <= all_held ? secs_left_r : 3'd0;
            rest_p_r <= restore_done;
            all_on_r <= test_on;
        end
    end

    // Shared blink base; also paces the hold timers to keep them narrow
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flash_cnt_r <= '0;
            flash_r <= 1'b0;
        end else if (flash_cnt_r == 32'(loop_det_pkg::FLASH3_CYC - 1)) begin
            flash_cnt_r <= '0;
            flash_r <= !flash_r;
        end else begin
            flash_cnt_r <= flash_cnt_r + 32'd1;
        end
    end

    // Settings change through the switch handler port and return to defaults on a restore
    always_ff @(posedge clock) begin
        for (int i = 0; i < 4; i++) begin
            if (!rst_n || restore_done) begin
                sens_r[i] <= loop_det_pkg::SENS_DEF;
                freq_r[i] <= loop_det_pkg::FREQ_DEF;
            end else if (set_we && set_ch == 2'(i)) begin
                sens_r[i] <= set_sens;
                freq_r[i] <= set_freq;
            end
        end
    end

    always_ff @(posedge clock) begin
        for (int i = 0; i < 4; i++) begin
            if (!rst_n) begin
                chreset_r[i] <= 1'b1;
            end else if (set_we && set_ch == 2'(i)
                         && (set_sens != sens_r[i] || set_freq != freq_r[i])) begin
                chreset_r[i] <= 1'b1;
            end else if (st_r == loop_det_pkg::ST_EVAL && ch_r == 2'(i)) begin
                chreset_r[i] <= 1'b0;
            end
        end
    end

    // Scan sequencer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_r <= loop_det_pkg::ST_ENABLE;
            ch_r <= '0;
            ncyc_r <= '0;
            acc_r <= '0;
            stall_r <= '0;
            sq_d_r <= 1'b0;
        end else begin
            sq_d_r <= sq_in;
            unique case (st_r)
                loop_det_pkg::ST_ENABLE: begin
                    // Wait for first edge so the sample covers whole cycles
                    ncyc_r <= cycles_for(cur_sens);
                    if (sq_rise) begin
                        acc_r <= '0;
                        stall_r <= '0;
                        st_r <= loop_det_pkg::ST_SAMPLE;
                    end else if (stall_out) begin
                        // Dead oscillator is reported as out of range
                        acc_r <= loop_det_pkg::CNT_MAX + 24'd1;
                        stall_r <= '0;
                        st_r <= loop_det_pkg::ST_EVAL;
                    end else begin
                        acc_r <= '0;
                        stall_r <= stall_r + 24'd1;
                    end
                end
                loop_det_pkg::ST_SAMPLE: begin
                    if (tick_32m) begin
                        acc_r <= acc_r + 24'd1;
                    end
                    if (acc_r > loop_det_pkg::CNT_MAX) begin
                        // Runaway sample from a slow loop ends early as a fault
                        st_r <= loop_det_pkg::ST_EVAL;
                    end else if (sq_rise) begin
                        ncyc_r <= ncyc_r - 8'd1;
                        if (ncyc_r == 8'd1) begin
                            st_r <= loop_det_pkg::ST_EVAL;
                        end
                    end
                end
                loop_det_pkg::ST_EVAL: begin
                    st_r <= loop_det_pkg::ST_ENABLE;
                    ch_r <= ch_r + 2'd1;
                end
            endcase
        end
    end

    // Per-channel evaluation once per sample
    always_ff @(posedge clock) begin
        for (int i = 0; i < 4; i++) begin
            if (!rst_n) begin
                ref_r[i] <= '0;
                last_r[i] <= '0;
                det_r[i] <= 1'b0;
                fail_r[i] <= 1'b0;
                mem_r[i] <= 1'b0;
                hold_r[i] <= '0;
            end else if (eval_now && ch_r == 2'(i)) begin
                last_r[i] <= acc_r;
                if (chreset_r[i]) begin
                    ref_r[i] <= acc_r; // Retune on channel reset
                    det_r[i] <= 1'b0;
                    fail_r[i] <= range_bad;
                    mem_r[i] <= 1'b0;
                end else begin
                    fail_r[i] <= eval_fail;
                    mem_r[i] <= mem_r[i] | eval_fail;
                    det_r[i] <= eval_det;
                    if (eval_track) begin
                        ref_r[i] <= ref_tracked;
                    end
                    if (eval_det) begin
                        hold_r[i] <= hold_ticks;
                    end
                end
            end else if (hold_r[i] != '0 && flash_cnt_r == '0) begin
                hold_r[i] <= hold_r[i] - 16'd1;
            end
        end
    end

    // Per-channel output decisions
    wire [3:0] forced;
    wire [3:0] holding;
    wire [3:0] call_nxt;
    wire [3:0] led_nxt;

    for (genvar g = 0; g < 4; g++) begin : g_chan
        assign forced[g] = (sens_r[g] == loop_det_pkg::SENS_CALL);
        assign holding[g] = (hold_r[g] != '0);
        // Fail-safe wins over the timers so a broken loop never drops its call
        assign call_nxt[g] = det_r[g] || holding[g] || fail_r[g] || forced[g];
        assign led_nxt[g] = (forced[g] || mem_r[g]) ? flash_r
                          : (det_r[g] || holding[g]);
    end

    always_ff @(posedge clock) begin
        for (int i = 0; i < 4; i++) begin
            if (!rst_n) begin
                osc_en_r[i] <= 1'b0;
                call_r[i] <= 1'b0;
                led_r[i] <= 1'b0;
            end else begin
                osc_en_r[i] <= !eval_now && ch_r == 2'(i);
                call_r[i] <= call_nxt[i];
                led_r[i] <= led_nxt[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dcount_r <= '0;
            dpct_r <= '0;
        end else begin
            dcount_r <= last_r[disp_ch];
            // Percentage is held between samples of the shown channel
            if (eval_now && ch_r == disp_ch) begin
                dpct_r <= pct_sat;
            end
        end
    end

    assign osc_en = osc_en_r;
    assign cap_sel = {freq_r[3], freq_r[2], freq_r[1], freq_r[0]};
    assign call_out = call_r;
    assign led_out = led_r;
    assign fail_out = fail_r;
    assign fail_mem = mem_r;
    assign disp_count = dcount_r;
    assign disp_pct = dpct_r;
    assign disp_all_on = all_on_r;
    assign restore_countdown = cd_r;
    assign restore_pulse = rest_p_r;
endmodule

// file: tb/loop_det_sva.sv
// Purpose: Port checker for the loop period detector
// Assumes: Bound to loop_period_detector, one clock domain
// Notes: Latencies allow a few cycles of slack
`timescale 1ns/1ps
module loop_det_sva (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] switch_in,
    input wire logic set_we,
    input wire logic [3:0] osc_en,
    input wire logic [11:0] cap_sel,
    input wire logic [3:0] call_out,
    input wire logic [3:0] fail_out,
    input wire logic [3:0] fail_mem,
    input wire logic disp_all_on,
    input wire logic [2:0] restore_countdown,
    input wire logic restore_pulse
);
    logic [3:0] last_en_r;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clock) begin
        if (!rst_n)
            last_en_r <= 4'h0;
        else if (osc_en != 4'h0)
            last_en_r <= osc_en;
    end
    a_osc_one_hot: assert property ($onehot0(osc_en))
        else $error("more than one oscillator enabled");
    a_scan_next_ch: assert property ((osc_en != 4'h0 && last_en_r != 4'h0 && osc_en != last_en_r)
        |-> osc_en == {last_en_r[2:0], last_en_r[3]}) else $error("scan order broken");
    a_eval_gap: assert property ((osc_en != 4'h0 && $past(osc_en) != 4'h0)
        |-> osc_en == $past(osc_en)) else $error("channel switched without eval cycle");
    a_display_test: assert property ($stable(switch_in) [*3]
        |-> disp_all_on == ($countones(switch_in) inside {2, 3})) else $error("display test wrong");
    a_countdown_idle: assert property ((switch_in != 4'hf) [*3]
        |-> restore_countdown == 3'h0) else $error("countdown without all switches");
    a_restore_held: assert property (restore_pulse |-> $past(switch_in) == 4'hf)
        else $error("restore without all switches held");
    a_fail_calls: assert property ((fail_out != 4'h0 && $past(fail_out, 3) == fail_out)
        |-> (call_out & fail_out) == fail_out) else $error("failed channel not calling");
    a_fail_memory: assert property ($rose(|fail_out) |-> ##[0:2] ((fail_mem & fail_out) != 4'h0))
        else $error("fail memory not set");
    a_cap_kept: assert property ($changed(cap_sel)
        |-> $past(set_we) || $past(set_we, 2) || $past(restore_pulse) || $past(restore_pulse, 2))
        else $error("capacitor select changed on its own");
endmodule
bind loop_period_detector loop_det_sva chk (.clock, .rst_n, .switch_in, .set_we, .osc_en,
    .cap_sel, .call_out, .fail_out, .fail_mem, .disp_all_on, .restore_countdown, .restore_pulse);

// file: tb/loop_osc_model.sv
// Purpose: Four loop oscillators into one squaring circuit
// Assumes: Half period per channel in clock cycles
// Notes: Output rests low while no oscillator is enabled
`timescale 1ns/1ps
module loop_osc_model (
    input wire logic clock,
    input wire logic [3:0] osc_en,
    input wire logic [31:0] half_per,
    output logic sq_in
);
    logic [7:0] cnt_r;
    wire [1:0] sel = osc_en[1] ? 2'h1 : osc_en[2] ? 2'h2 : osc_en[3] ? 2'h3 : 2'h0;
    wire [7:0] half = half_per[sel*8 +: 8];
    initial cnt_r = 8'h00;
    initial sq_in = 1'b0;
    always @(posedge clock) begin
        if (osc_en == 4'h0) begin
            cnt_r <= 8'h00;
            sq_in <= 1'b0;
        end else if (cnt_r + 8'h01 >= half) begin
            cnt_r <= 8'h00;
            sq_in <= ~sq_in;
        end else
            cnt_r <= cnt_r + 8'h01;
    end
endmodule

// file: tb/loop_period_detector_tb.sv
// Purpose: Self-checking bench for the loop period detector
// Assumes: Sensitivity 1 gives 16 oscillations per sample
// Notes: Count tick held high to keep samples short
`timescale 1ns/1ps
module loop_period_detector_tb;
    logic clock = 0, rst_n = 0, set_we = 0;
    logic [3:0] switch_in = 4'h0, set_sens = 4'h0;
    logic [1:0] set_ch = 2'h0;
    logic [2:0] set_freq = 3'h0;
    // Fast channel 3 keeps its long forced-call sample short
    logic [31:0] half_per = 32'h02242424;
    logic [23:0] disp_count;
    logic [7:0] disp_pct;
    logic sq_in, disp_all_on, restore_pulse;
    logic [3:0] osc_en, call_out, led_out, fail_out, fail_mem;
    logic [11:0] cap_sel;
    logic [2:0] restore_countdown;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    always #2 clock = ~clock;
    loop_period_detector dut (.clock(clock), .rst_n(rst_n), .tick_32m(1'b1), .sq_in(sq_in),
        .switch_in(switch_in), .set_we(set_we), .set_ch(set_ch), .set_sens(set_sens),
        .set_freq(set_freq), .hold_ticks(16'h0000), .disp_ch(2'h0), .osc_en(osc_en),
        .cap_sel(cap_sel), .call_out(call_out), .led_out(led_out), .fail_out(fail_out),
        .fail_mem(fail_mem), .disp_count(disp_count), .disp_pct(disp_pct),
        .disp_all_on(disp_all_on),
        .restore_countdown(restore_countdown), .restore_pulse(restore_pulse));
    loop_osc_model osc (.clock(clock), .osc_en(osc_en), .half_per(half_per), .sq_in(sq_in));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic write(input logic [1:0] ch, input logic [3:0] s, input logic [2:0] f);
        set_we <= 1'b1;
        set_ch <= ch;
        set_sens <= s;
        set_freq <= f;
        @(posedge clock);
        set_we <= 1'b0;
        @(posedge clock);
    endtask
    task automatic t_setup();
        write(2'h0, 4'h1, 3'h1);
        write(2'h1, 4'h1, 3'h2);
        write(2'h2, 4'h1, 3'h3);
        write(2'h3, loop_det_pkg::SENS_CALL, 3'h4);
        wait_cyc(3);
        check("cap_sel", cap_sel, 12'h8d1);
        wait_cyc(10000);
        check("call_out", call_out, 4'h8);
        check("fail_out", fail_out, 4'h0);
        check("disp_count", disp_count[15:0], 16'h0480);
        check("disp_pct", disp_pct, 8'h00);
        $display("setup test done");
    endtask
    task automatic t_switch();
        switch_in <= 4'h3;
        wait_cyc(4);
        check("disp_all_on", disp_all_on, 1'b1);
        switch_in <= 4'h7;
        wait_cyc(4);
        check("disp_all_on", disp_all_on, 1'b1);
        switch_in <= 4'h1;
        wait_cyc(4);
        check("disp_all_on", disp_all_on, 1'b0);
        switch_in <= 4'hf;
        wait_cyc(4);
        check("restore_countdown", restore_countdown, 3'h5);
        switch_in <= 4'h7;
        wait_cyc(4);
        check("restore_countdown", restore_countdown, 3'h0);
        check("restore_pulse", restore_pulse, 1'b0);
        check("cap_sel", cap_sel, 12'h8d1);
        check("call_out", call_out, 4'h8);
        switch_in <= 4'h0;
        $display("switch test done");
    endtask
    task automatic t_vehicle();
        half_per[15:8] <= 8'h22;
        wait_cyc(10000);
        check("call_out", call_out, 4'ha);
        check("fail_out", fail_out, 4'h0);
        check("led_out", led_out, 4'h2);
        half_per[15:8] <= 8'h24;
        wait_cyc(10000);
        check("call_out", call_out, 4'h8);
        $display("vehicle test done");
    endtask
    task automatic t_fail();
        half_per[23:16] <= 8'h10;
        wait_cyc(10000);
        check("fail_out", fail_out, 4'h4);
        check("call_out", call_out, 4'hc);
        half_per[23:16] <= 8'h24;
        wait_cyc(10000);
        check("fail_out", fail_out, 4'h0);
        check("fail_mem", fail_mem, 4'h4);
        $display("fail test done");
    endtask
    // Ceiling sits well above the five waits of about ten thousand cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 70000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        wait_cyc(5);
        rst_n <= 1'b1;
        @(posedge clock);
        t_setup();
        t_switch();
        t_vehicle();
        t_fail();
        end_of_test();
    end
endmodule
